// [shared/pcd_pkg.sv]
package pcd_pkg;
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned INT_PULSE_NS = 1000;
  localparam int unsigned INT_PULSE_CYC = (INT_PULSE_NS / CLK_NS) < 1 ? 1 : (INT_PULSE_NS / CLK_NS);
  localparam int unsigned PW = 10;
  localparam int unsigned HIST_DEPTH = 12;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] SLOPE_SCALE_SH = 8'h07;
  localparam logic [15:0] T_MAX = 16'hffff;
  localparam logic [4:0] FRAME_EDGES = 5'h10;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_FIX_HI = 8'h08;
  localparam logic [7:0] A_FIX_LO = 8'h0c;
  localparam logic [7:0] A_DEB = 8'h10;
  localparam logic [7:0] A_MIN = 8'h14;
  localparam logic [7:0] A_REL_HI = 8'h18;
  localparam logic [7:0] A_REL_LO = 8'h1c;
  localparam logic [7:0] A_SLOPE_HI = 8'h20;
  localparam logic [7:0] A_SLOPE_LO = 8'h24;
  localparam logic [7:0] A_STATUS = 8'h28;
  localparam logic [7:0] A_CMD = 8'h2c;
  localparam logic [7:0] A_SAMPLE = 8'h30;
  localparam logic [7:0] A_INDEX = 8'h34;
  localparam logic [7:0] A_HIST0 = 8'h40;
  localparam int unsigned CTRL_FIX_EN = 0;
  localparam int unsigned CTRL_REL_EN = 1;
  localparam int unsigned CTRL_RATE_EN = 2;
  localparam int unsigned CTRL_PSW_EN = 3;
  localparam int unsigned ST_SUMMARY = 0;
  localparam int unsigned ST_FIX = 1;
  localparam int unsigned ST_REL = 2;
  localparam int unsigned ST_RATE = 3;
  localparam int unsigned CMD_ACK = 0;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'h03e8;
  localparam logic [7:0] DEB_RST = 8'h03;
  localparam logic [7:0] MIN_RST = 8'h02;
  localparam logic [15:0] FIX_RST = 16'h0200;
  localparam logic [15:0] REL_RST = 16'h0010;
  localparam logic [15:0] SLOPE_RST = 16'h0100;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {PS_IDLE = 2'b00, PS_NOTIFY = 2'b01, PS_ACTIVE = 2'b10} pcd_pstate_e;
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_ADDR = 2'b01, RD_DATA = 2'b10, RD_RESP = 2'b11} pcd_rd_e;
endpackage

// [hw/pcd_sync.sv]
`timescale 1ns/100ps
module pcd_sync #(
  parameter int unsigned W = 3,
  parameter logic [W-1:0] RST = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pcd_sync_s;
  pcd_sync_s st_q;
  pcd_sync_s st_d;
  always_comb
  begin
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '{s1: RST, s2: RST};
    else
      st_q <= st_d;
  end
  assign q = st_q.s2;
endmodule

// [hw/pcd_hist_mem.sv]
`timescale 1ns/100ps
module pcd_hist_mem #(
  parameter int unsigned DW = 10,
  parameter int unsigned DEPTH = 12,
  parameter int unsigned AW = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } pcd_mem_s;
  pcd_mem_s st_q;
  pcd_mem_s st_d;
  always_comb
  begin
    st_d = st_q;
    if (we && (waddr < AW'(DEPTH)))
      st_d.mem[waddr] = wdata;
    // unwritten slots read zero, out of range reads zero
    st_d.rd = (raddr < AW'(DEPTH)) ? st_q.mem[raddr] : '0;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign rdata = st_q.rd;
endmodule

// [hw/pcd_top.sv]
`timescale 1ns/100ps
module pcd_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [pcd_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pcd_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pcd_pkg::PW-1:0] pressure_in,
  input wire logic wake_n,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  output logic serial_enable,
  output logic power_switch_enable_pin,
  output logic int_pin
);
  import pcd_pkg::*;
  localparam int unsigned CW = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic aw_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic w_have;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    pcd_rd_e rd_ph;
    logic [ADDR_W-1:0] araddr;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [15:0] period;
    logic [15:0] fix_lim;
    logic [7:0] deb_lim;
    logic [7:0] min_step;
    logic [15:0] rel_lim;
    logic [15:0] slope_lim;
    logic ack;
    logic [3:0] flags;
    pcd_pstate_e pst;
    logic [15:0] tmr;
    logic det_go;
    logic [PW-1:0] cur;
    logic [PW-1:0] prev;
    logic have_prev;
    logic [CW-1:0] cnt_fix;
    logic [CW-1:0] cnt_rise;
    logic [CW-1:0] cnt_rel;
    logic [CW-1:0] cnt_rate;
    logic [PW-1:0] ref_rel;
    logic [PW-1:0] ref_rate;
    logic [15:0] t_rise;
    logic [3:0] widx;
    logic [7:0] pulse_cnt;
    logic int_pin;
    logic psw;
    logic se;
    logic sclk_prev;
    logic cs_prev;
    logic [4:0] edges;
    logic frame_seen;
  } pcd_top_s;

  pcd_top_s st_q;
  pcd_top_s st_d;
  logic [2:0] pins_s;
  logic wake_s;
  logic cs_s;
  logic sclk_s;
  logic [PW-1:0] hist_rd;
  logic [3:0] hist_ridx;
  logic above_fix;
  logic rising;
  logic [3:0] raise;
  logic [23:0] slope_val;

  function automatic logic [CW-1:0] sat_step(input logic [CW-1:0] c, input logic up);
    if (up)
      sat_step = (c == '1) ? c : c + 1'b1;
    else
      sat_step = (c == '0) ? c : c - 1'b1;
  endfunction

  function automatic logic [PW-1:0] rise_of(input logic [PW-1:0] a, input logic [PW-1:0] b);
    rise_of = (a > b) ? a - b : '0;
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  pcd_sync #(.W(3), .RST(3'b111)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({wake_n, spi_cs_n, spi_sclk}),
    .q(pins_s)
  );
  assign wake_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign sclk_s = pins_s[0];

  assign hist_ridx = 4'((st_q.araddr - A_HIST0) >> 2);
  pcd_hist_mem #(.DW(PW), .DEPTH(HIST_DEPTH), .AW(4)) u_hist (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(st_q.det_go),
    .waddr(st_q.widx),
    .wdata(st_q.cur),
    .raddr(hist_ridx),
    .rdata(hist_rd)
  );

  always_comb
  begin
    st_d = st_q;
    raise = '0;
    // step compare done at 17 bits so a large step cannot wrap
    above_fix = {6'h00, st_q.cur} > st_q.fix_lim;
    rising = st_q.have_prev && ({7'h00, st_q.cur} > {7'h00, st_q.prev} + {9'h000, st_q.min_step});
    slope_val = 24'({14'h0000, rise_of(st_q.cur, st_q.ref_rate)} << SLOPE_SCALE_SH) / 24'({1'b0, st_q.t_rise} + 17'h1);

    // register bus: write side, address and data in either order
    if (s_axi_awvalid && st_q.awready)
    begin
      st_d.awaddr = s_axi_awaddr;
      st_d.aw_have = 1'b1;
    end
    if (s_axi_wvalid && st_q.wready)
    begin
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
      st_d.w_have = 1'b1;
    end
    if (st_q.bvalid && s_axi_bready)
      st_d.bvalid = 1'b0;
    st_d.ack = 1'b0;
    if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = RESP_OKAY;
      unique case (st_q.awaddr)
        A_CTRL: st_d.ctrl = st_q.wstrb[0] ? st_q.wdata[3:0] : st_q.ctrl;
        A_PERIOD: st_d.period = wmerge(st_q.period, st_q.wdata, st_q.wstrb);
        A_FIX_HI: st_d.fix_lim[15:8] = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.fix_lim[15:8];
        A_FIX_LO: st_d.fix_lim[7:0] = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.fix_lim[7:0];
        A_DEB: st_d.deb_lim = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.deb_lim;
        A_MIN: st_d.min_step = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.min_step;
        A_REL_HI: st_d.rel_lim[15:8] = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.rel_lim[15:8];
        A_REL_LO: st_d.rel_lim[7:0] = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.rel_lim[7:0];
        A_SLOPE_HI: st_d.slope_lim[15:8] = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.slope_lim[15:8];
        A_SLOPE_LO: st_d.slope_lim[7:0] = st_q.wstrb[0] ? st_q.wdata[7:0] : st_q.slope_lim[7:0];
        A_CMD: st_d.ack = st_q.wstrb[0] && st_q.wdata[CMD_ACK];
        A_STATUS, A_SAMPLE, A_INDEX: st_d.bresp = RESP_OKAY;
        default: st_d.bresp = RESP_SLVERR;
      endcase
    end
    st_d.awready = !st_d.aw_have;
    st_d.wready = !st_d.w_have;

    // read side: fixed latency so history words come out of the memory register
    unique case (st_q.rd_ph)
      RD_IDLE:
        if (s_axi_arvalid && st_q.arready)
        begin
          st_d.araddr = s_axi_araddr;
          st_d.rd_ph = RD_ADDR;
        end
      RD_ADDR: st_d.rd_ph = RD_DATA;
      RD_DATA:
      begin
        st_d.rd_ph = RD_RESP;
        st_d.rvalid = 1'b1;
        st_d.rresp = RESP_OKAY;
        st_d.rdata = '0;
        if (st_q.araddr >= A_HIST0 && st_q.araddr < A_HIST0 + 8'(4 * HIST_DEPTH) && st_q.araddr[1:0] == 2'h0)
          st_d.rdata = {22'h000000, hist_rd};
        else
          unique case (st_q.araddr)
            A_CTRL: st_d.rdata = {28'h0000000, st_q.ctrl};
            A_PERIOD: st_d.rdata = {16'h0000, st_q.period};
            A_FIX_HI: st_d.rdata = {24'h000000, st_q.fix_lim[15:8]};
            A_FIX_LO: st_d.rdata = {24'h000000, st_q.fix_lim[7:0]};
            A_DEB: st_d.rdata = {24'h000000, st_q.deb_lim};
            A_MIN: st_d.rdata = {24'h000000, st_q.min_step};
            A_REL_HI: st_d.rdata = {24'h000000, st_q.rel_lim[15:8]};
            A_REL_LO: st_d.rdata = {24'h000000, st_q.rel_lim[7:0]};
            A_SLOPE_HI: st_d.rdata = {24'h000000, st_q.slope_lim[15:8]};
            A_SLOPE_LO: st_d.rdata = {24'h000000, st_q.slope_lim[7:0]};
            A_STATUS: st_d.rdata = {28'h0000000, st_q.flags};
            A_CMD: st_d.rdata = '0;
            A_SAMPLE: st_d.rdata = {22'h000000, st_q.cur};
            A_INDEX: st_d.rdata = {28'h0000000, st_q.widx};
            default: st_d.rresp = RESP_SLVERR;
          endcase
      end
      RD_RESP:
        if (s_axi_rready)
        begin
          st_d.rvalid = 1'b0;
          st_d.rd_ph = RD_IDLE;
        end
    endcase
    st_d.arready = (st_d.rd_ph == RD_IDLE);

    // periodic sampling
    if (st_q.tmr >= st_q.period)
    begin
      st_d.tmr = '0;
      st_d.cur = pressure_in;
      st_d.prev = st_q.cur;
      st_d.det_go = 1'b1;
    end
    else
    begin
      st_d.tmr = st_q.tmr + 16'h0001;
      st_d.det_go = 1'b0;
    end

    // detectors, one cycle after the sample is taken
    if (st_q.det_go)
    begin
      st_d.widx = (st_q.widx == 4'(HIST_DEPTH - 1)) ? 4'h0 : st_q.widx + 4'h1;
      // prev only valid from the second sample on
      st_d.have_prev = 1'b1;
      if (st_q.ctrl[CTRL_FIX_EN])
      begin
        st_d.cnt_fix = sat_step(st_q.cnt_fix, above_fix);
        raise[ST_FIX] = st_d.cnt_fix > st_q.deb_lim;
      end
      else
        st_d.cnt_fix = '0;
      if (st_q.ctrl[CTRL_REL_EN])
      begin
        st_d.cnt_rise = sat_step(st_q.cnt_rise, rising);
        st_d.cnt_rel = sat_step(st_q.cnt_rel, (st_d.cnt_rise != '0)
          && ({6'h00, rise_of(st_q.cur, st_q.ref_rel)} > st_q.rel_lim));
        raise[ST_REL] = st_d.cnt_rel > st_q.deb_lim;
        if (st_d.cnt_rise == '0 && st_d.cnt_rel == '0)
          st_d.ref_rel = st_q.cur;
      end
      else
      begin
        st_d.cnt_rise = '0;
        st_d.cnt_rel = '0;
        st_d.ref_rel = st_q.cur;
      end
      if (st_q.ctrl[CTRL_RATE_EN])
      begin
        st_d.cnt_rate = sat_step(st_q.cnt_rate, rising);
        st_d.t_rise = (st_d.cnt_rate != '0) ? st_q.t_rise + 16'h0001 : '0;
        // restart rather than let t wrap and corrupt the slope
        if (st_q.t_rise == T_MAX)
        begin
          st_d.cnt_rate = '0;
          st_d.t_rise = '0;
        end
        raise[ST_RATE] = (st_d.cnt_rate > st_q.deb_lim) && (slope_val > {8'h00, st_q.slope_lim});
        if (st_d.cnt_rate == '0)
          st_d.ref_rate = st_q.cur;
      end
      else
      begin
        st_d.cnt_rate = '0;
        st_d.t_rise = '0;
        st_d.ref_rate = st_q.cur;
      end
      raise[ST_SUMMARY] = |raise[3:1];
    end
    // a raise in the ack cycle survives the clear
    st_d.flags = (st_q.ack ? 4'h0 : st_q.flags) | raise;

    // link activity: a frame counts once cs rises after exactly one word of clocks
    st_d.sclk_prev = sclk_s;
    st_d.cs_prev = cs_s;
    if (!cs_s && sclk_s && !st_q.sclk_prev && st_q.edges != '1)
      st_d.edges = st_q.edges + 5'h01;
    if (cs_s && !st_q.cs_prev)
    begin
      st_d.edges = '0;
      if (st_q.edges == FRAME_EDGES && st_q.pst != PS_IDLE)
        st_d.frame_seen = 1'b1;
    end

    // power state
    unique case (st_q.pst)
      PS_IDLE:
      begin
        st_d.frame_seen = 1'b0;
        if (raise[ST_SUMMARY])
        begin
          st_d.pst = PS_NOTIFY;
          st_d.int_pin = 1'b1;
          st_d.pulse_cnt = 8'(INT_PULSE_CYC - 1);
          st_d.psw = st_q.ctrl[CTRL_PSW_EN];
        end
        else if (!wake_s)
          st_d.pst = PS_ACTIVE;
      end
      PS_NOTIFY:
        if (st_q.pulse_cnt == 8'h00)
        begin
          st_d.int_pin = 1'b0;
          st_d.pst = PS_ACTIVE;
        end
        else
          st_d.pulse_cnt = st_q.pulse_cnt - 8'h01;
      PS_ACTIVE:
        if (st_q.frame_seen && cs_s && wake_s)
        begin
          st_d.pst = PS_IDLE;
          st_d.psw = 1'b0;
        end
      default: st_d.pst = PS_IDLE;
    endcase
    st_d.se = (st_d.pst != PS_IDLE);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
      st_q.rd_ph <= RD_IDLE;
      st_q.pst <= PS_IDLE;
      st_q.ctrl <= CTRL_RST;
      st_q.period <= PERIOD_RST;
      st_q.fix_lim <= FIX_RST;
      st_q.deb_lim <= DEB_RST;
      st_q.min_step <= MIN_RST;
      st_q.rel_lim <= REL_RST;
      st_q.slope_lim <= SLOPE_RST;
      st_q.sclk_prev <= 1'b1;
      st_q.cs_prev <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign serial_enable = st_q.se;
  assign power_switch_enable_pin = st_q.psw;
  assign int_pin = st_q.int_pin;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  summary_set_a: assert property (st_q.det_go && (raise[3:1] != 3'h0) |=> st_q.flags[ST_SUMMARY])
    else $error("summary flag missed");
  ack_clear_a: assert property (st_q.ack && !st_q.det_go |=> st_q.flags == 4'h0)
    else $error("ack did not clear flags");
  fix_zero_a: assert property (st_q.det_go && st_q.cnt_fix == '0 && !above_fix |=> st_q.cnt_fix == '0)
    else $error("fixed counter went below zero");
  fix_flag_a: assert property (st_q.det_go && st_q.ctrl[CTRL_FIX_EN] && st_d.cnt_fix > st_q.deb_lim
    |=> st_q.flags[ST_FIX])
    else $error("fixed flag not raised");
  ref_load_a: assert property (st_q.det_go && st_q.ctrl[CTRL_REL_EN] && st_d.cnt_rise == '0 && st_d.cnt_rel == '0
    |=> st_q.ref_rel == $past(st_q.cur))
    else $error("reference not loaded");
  pulse_len_a: assert property ($rose(st_q.int_pin) |-> st_q.int_pin [*8] ##0 serial_enable)
    else $error("interrupt pulse too short");
  no_pulse_active_a: assert property (st_q.pst == PS_ACTIVE |=> !$rose(st_q.int_pin))
    else $error("pulse while transfers outstanding");
  stay_active_a: assert property (st_q.pst == PS_ACTIVE && !st_q.frame_seen |=> serial_enable)
    else $error("left active before transfer");
  wake_enter_a: assert property (st_q.pst == PS_IDLE && !wake_s && !raise[ST_SUMMARY] |=> serial_enable)
    else $error("wake did not enable serial");
  hist_wrap_a: assert property (st_q.det_go && st_q.widx == 4'(HIST_DEPTH - 1) |=> st_q.widx == 4'h0)
    else $error("history index did not wrap");
endmodule

// [test/pcd_host.sv]
`timescale 1ns/100ps
module pcd_host (
  input wire logic int_pin,
  input wire logic serial_enable,
  input wire logic wake_req,
  input wire logic [4:0] edges,
  output logic wake_n,
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic done
);
  // clock stands still outside frames
  initial
  begin
    wake_n = 1'b1;
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    done = 1'b0;
    forever
    begin
      @(posedge int_pin or posedge wake_req);
      done = 1'b0;
      if (wake_req)
        wake_n = 1'b0;
      wait (serial_enable === 1'b1);
      #500;
      spi_cs_n = 1'b0;
      repeat (edges)
      begin
        #160 spi_sclk = 1'b1;
        #160 spi_sclk = 1'b0;
      end
      #160 spi_cs_n = 1'b1;
      wake_n = 1'b1;
      done = 1'b1;
    end
  end
endmodule

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import pcd_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic se, psw, int_pin, wake_n, cs_n, sclk, wake_req, done;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb, ctrl_q, st;
  logic [1:0] bresp, rresp;
  logic [4:0] edges;
  logic [PW-1:0] pressure_in;
  int bad_count, comparisons, cyc, hi, pulses, fc, ic, rc, sc, t, rref, sref, prev, cur, idx, deb, mn;
  bit hp, int_prev, se_prev;
  int hist [HIST_DEPTH];
  logic [7:0] ra [9] = '{A_CTRL, A_FIX_HI, A_FIX_LO, A_DEB, A_MIN, A_REL_HI, A_REL_LO, A_SLOPE_HI, A_SLOPE_LO};
  logic [31:0] rv [9] = '{CTRL_RST, FIX_RST[15:8], FIX_RST[7:0], DEB_RST, MIN_RST, REL_RST[15:8], REL_RST[7:0],
    SLOPE_RST[15:8], SLOPE_RST[7:0]};
  logic [3:0] modes [4] = '{4'h1, 4'h2, 4'h4, 4'hf};

  pcd_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pressure_in(pressure_in),
    .wake_n(wake_n), .spi_cs_n(cs_n), .spi_sclk(sclk), .serial_enable(se), .power_switch_enable_pin(psw),
    .int_pin(int_pin));
  pcd_host host_u (.int_pin(int_pin), .serial_enable(se), .wake_req(wake_req), .edges(edges), .wake_n(wake_n),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .done(done));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    check("bresp", bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    d = rdata;
    check("rresp", rresp, er);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, d, RESP_OKAY);
    check(nm, d, e);
  endtask

  task automatic step(input int p);
    bit up;
    up = hp && p > prev + mn;
    fc = !ctrl_q[0] ? 0 : p > int'(FIX_RST) ? fc + 1 : fc > 0 ? fc - 1 : 0;
    ic = !ctrl_q[1] ? 0 : up ? ic + 1 : ic > 0 ? ic - 1 : 0;
    rc = !ctrl_q[1] ? 0 : ic > 0 && p - rref > int'(REL_RST) ? rc + 1 : rc > 0 ? rc - 1 : 0;
    sc = !ctrl_q[2] ? 0 : up ? sc + 1 : sc > 0 ? sc - 1 : 0;
    if (sc > deb && p > sref && (p - sref) * 128 / (t + 1) > int'(SLOPE_RST)) st[3] = 1'b1;
    t = sc > 0 ? t + 1 : 0;
    if (sc == 0) sref = p;
    if (ic == 0 && rc == 0) rref = p;
    if (fc > deb) st[1] = 1'b1;
    if (rc > deb) st[2] = 1'b1;
    if (st[3:1] != 0) st[0] = 1'b1;
    prev = p;
    hp = 1;
    hist[idx] = p;
    idx = (idx + 1) % HIST_DEPTH;
  endtask

  // samples are seen through the index, so the model never drifts out of step
  task automatic next_sample();
    logic [31:0] d;
    do
      axi_rd(A_INDEX, d, RESP_OKAY);
    while (d == idx);
    step(cur);
    check("index", d, idx);
    rd_chk("sample", A_SAMPLE, cur);
    rd_chk("status", A_STATUS, st);
    if (st != 0)
    begin
      axi_wr(A_CMD, 32'h1, RESP_OKAY);
      st = 4'h0;
      rd_chk("status_ack", A_STATUS, st);
      rd_chk("cmd", A_CMD, 32'h0);
    end
  endtask

  task automatic frame(input logic [4:0] e, input logic exp);
    @(posedge aclk);
    wake_req <= 1'b0;
    edges <= e;
    @(posedge aclk);
    wake_req <= 1'b1;
    repeat (5) @(posedge aclk);
    @(negedge aclk);
    check("wake", se, 1'b1);
    rd_chk("active_rd", A_DEB, 32'h2);
    @(posedge done);
    repeat (8) @(posedge aclk);
    @(negedge aclk);
    check("release", se, exp);
  endtask

  always @(negedge aclk)
  begin
    if (int_pin === 1'b1 && !int_prev)
    begin
      pulses++;
      check("int_quiet", se_prev, 1'b0);
      check("int_se", se, 1'b1);
      check("psw", psw, ctrl_q[3]);
    end
    if (int_pin === 1'b1)
      hi++;
    else if (hi > 0)
    begin
      check("int_len", hi, INT_PULSE_CYC);
      hi = 0;
    end
    int_prev = int_pin;
    se_prev = se;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      stop_test();
    end
  end

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wake_req} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    ctrl_q = 4'h0;
    st = 4'h0;
    edges = 5'h10;
    cur = 490;
    pressure_in = 10'(cur);
    deb = 2;
    mn = 1;
    void'($urandom(32'hd645));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk("period", A_PERIOD, PERIOD_RST);
    // short period keeps the run brief
    axi_wr(A_PERIOD, 32'h000000c8, RESP_OKAY);
    foreach (ra[k]) rd_chk("reset_val", ra[k], rv[k]);
    // unmapped reads answer an error with zero data
    axi_rd(8'h38, rd_d, RESP_SLVERR);
    check("unmapped", rd_d, 32'h0);
    axi_wr(8'h38, 32'h1, RESP_SLVERR);
    axi_wr(A_DEB, 32'h2, RESP_OKAY);
    axi_wr(A_MIN, 32'h1, RESP_OKAY);
    rd_chk("min", A_MIN, 32'h1);
    foreach (modes[m])
    begin
      ctrl_q = modes[m];
      axi_wr(A_CTRL, 32'(ctrl_q), RESP_OKAY);
      for (int i = 0; i < 20; i++)
      begin
        next_sample();
        cur = i == 19 ? 490 : (i >= 8 && i < 14) ? 100 + int'($urandom % 4) : cur + 2 + int'($urandom % 6);
        pressure_in <= 10'(cur);
      end
      for (int k = 0; k < HIST_DEPTH; k++) rd_chk("hist", A_HIST0 + 8'(4 * k), hist[k]);
    end
    ctrl_q = 4'h0;
    axi_wr(A_CTRL, 32'h0, RESP_OKAY);
    repeat (400) @(posedge aclk);
    frame(5'h10, 1'b0);
    frame(5'h0f, 1'b1);
    frame(5'h10, 1'b0);
    check("pulses", pulses > 0, 32'h1);
    stop_test();
  end
endmodule
